/* File: hdl/iec_top.sv */
/*
  interrupt enable and external edge select block with apb register access.
  holds three enable groups, the edge select register, the pending groups
  they gate, and the poll logic that raises a service request.
  assumes: apb master clocked by pclk; source events are one-cycle pulses
  synchronous to pclk; the core pulses poll before each instruction.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iec_regs.svh"
module iec_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_line_zero,
  input  wire logic        ext_irq_line_one,
  input  wire logic [22:0] src_event,
  input  wire logic        poll,
  input  wire logic        service_ack,
  output logic             svc_req,
  output logic [4:0]       svc_idx,
  output logic             irq
);
  iec_pkg::iec_state_t s_q;
  iec_pkg::iec_state_t s_d;
  logic                hit0;
  logic                hit1;

  // combined 23-bit views, bit 0 is highest priority
  function automatic logic [22:0] pack23(input iec_pkg::iec_byte_t a,
                                         input iec_pkg::iec_byte_t b,
                                         input iec_pkg::iec_byte_t c);
    pack23 = {c[6:0], b, a};
  endfunction

  // byte address to register index; unaligned or out of range gives 8'hFF
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    if (addr[1:0] != 2'b00 || addr[31:10] != 22'h0) begin
      reg_index = 8'hFF;
    end else begin
      reg_index = addr[9:2];
    end
  endfunction

  // first set bit, lowest index wins
  function automatic logic [4:0] first_set(input logic [22:0] v);
    first_set = 5'h00;
    for (int i = `IEC_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = i[4:0];
      end
    end
  endfunction

  iec_edge_detect u_edge0 (
    .pclk       (pclk),
    .presetn    (presetn),
    .line       (ext_irq_line_zero),
    .rising_sel (s_q.edge_sel[`IEC_LINE0_BIT]),
    .hit        (hit0)
  );

  iec_edge_detect u_edge1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .line       (ext_irq_line_one),
    .rising_sel (s_q.edge_sel[`IEC_LINE1_BIT]),
    .hit        (hit1)
  );

  logic        wr_acc;
  logic        rd_acc;
  logic [7:0]  idx;
  logic [22:0] pend_now;
  logic [22:0] mask_now;
  logic [22:0] seen;
  logic [22:0] events;
  logic [22:0] wr_clr;
  logic [22:0] svc_clr;
  logic [22:0] pend_nx;
  logic        mapped;

  // zero wait state slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~pwrite & ~penable;
  assign idx     = reg_index(paddr);
  assign mapped  = (idx == `IEC_IDX_PEND_A) || (idx == `IEC_IDX_PEND_B)
                || (idx == `IEC_IDX_PEND_C) || (idx == `IEC_IDX_MASK_A)
                || (idx == `IEC_IDX_MASK_B) || (idx == `IEC_IDX_MASK_C)
                || (idx == `IEC_IDX_EDGE_SEL) || (idx == `IEC_IDX_CORE);
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = s_q.rdata;
  assign svc_req = s_q.svc_req;
  assign svc_idx = s_q.svc_idx;

  // gating of requests by their enables, the view the core polls
  assign pend_now = pack23(s_q.pend_a, s_q.pend_b, s_q.pend_c);
  assign mask_now = pack23(s_q.mask_a, s_q.mask_b, s_q.mask_c);
  assign seen     = pend_now & mask_now;
  assign irq      = (|seen) & ~s_q.inhibit;

  // external line hits land on their fixed positions in group a
  always_comb begin
    events = src_event;
    events[`IEC_PEND_A_LINE0] = src_event[`IEC_PEND_A_LINE0] | hit0;
    events[`IEC_PEND_A_LINE1] = src_event[`IEC_PEND_A_LINE1] | hit1;
  end

  // clear masks: a written zero clears, a written one keeps
  always_comb begin
    wr_clr = 23'h0;
    if (wr_acc && pstrb[0]) begin
      unique case (idx)
        `IEC_IDX_PEND_A: wr_clr[7:0]   = ~pwdata[7:0];
        `IEC_IDX_PEND_B: wr_clr[15:8]  = ~pwdata[7:0];
        `IEC_IDX_PEND_C: wr_clr[22:16] = ~pwdata[6:0];
        default:         wr_clr        = 23'h0;
      endcase
    end
    svc_clr = 23'h0;
    if (service_ack && s_q.svc_req) begin
      svc_clr[s_q.svc_idx] = 1'b1;
    end
  end

  // an event in the cycle of its clear wins over the clear
  assign pend_nx = (pend_now & ~wr_clr & ~svc_clr) | events;

  // next state of every register
  always_comb begin
    s_d = s_q;
    s_d.pend_a = pend_nx[7:0];
    s_d.pend_b = pend_nx[15:8];
    s_d.pend_c = {1'b0, pend_nx[22:16]};
    if (wr_acc && pstrb[0]) begin
      unique case (idx)
        `IEC_IDX_MASK_A:   s_d.mask_a   = pwdata[7:0];
        `IEC_IDX_MASK_B:   s_d.mask_b   = pwdata[7:0];
        `IEC_IDX_MASK_C:   s_d.mask_c   = pwdata[7:0] & `IEC_MASK_C_VALID;
        `IEC_IDX_EDGE_SEL: s_d.edge_sel = pwdata[7:0] & `IEC_EDGE_VALID;
        `IEC_IDX_CORE:     s_d.inhibit  = pwdata[`IEC_CORE_INHIBIT];
        default:           s_d.inhibit  = s_q.inhibit;
      endcase
    end
    // taking service sets the inhibit flag so nothing nests
    if (service_ack && s_q.svc_req) begin
      s_d.inhibit = 1'b1;
    end
    // poll before an instruction: first enabled, uninhibited request
    if (poll) begin
      s_d.svc_req = (|seen) & ~s_q.inhibit;
      s_d.svc_idx = first_set(seen);
    end else if (service_ack) begin
      s_d.svc_req = 1'b0;
    end
    // read data captured in setup so it is stable through the access phase
    if (rd_acc) begin
      unique case (idx)
        `IEC_IDX_PEND_A:   s_d.rdata = {24'h0, s_q.pend_a};
        `IEC_IDX_PEND_B:   s_d.rdata = {24'h0, s_q.pend_b};
        `IEC_IDX_PEND_C:   s_d.rdata = {24'h0, s_q.pend_c};
        `IEC_IDX_MASK_A:   s_d.rdata = {24'h0, s_q.mask_a};
        `IEC_IDX_MASK_B:   s_d.rdata = {24'h0, s_q.mask_b};
        `IEC_IDX_MASK_C:   s_d.rdata = {24'h0, s_q.mask_c};
        `IEC_IDX_EDGE_SEL: s_d.rdata = {24'h0, s_q.edge_sel};
        `IEC_IDX_CORE:     s_d.rdata = {31'h0, s_q.inhibit};
        default:           s_d.rdata = 32'h0;
      endcase
    end
  end

  // the single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.mask_a   <= `IEC_RST_MASK;
      s_q.mask_b   <= `IEC_RST_MASK;
      s_q.mask_c   <= `IEC_RST_MASK;
      s_q.edge_sel <= `IEC_RST_EDGE;
      s_q.inhibit  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/iec_regs.svh */
/*
  register indexes, field positions, reset values and widths for the
  interrupt enable and edge select block.
  assumes: included by bare name; definitions only.
*/
`ifndef IEC_REGS_SVH
`define IEC_REGS_SVH

// printed offsets are not all multiples of four: these are indexes
`define IEC_IDX_PEND_A      8'h02
`define IEC_IDX_PEND_B      8'h03
`define IEC_IDX_PEND_C      8'h04
`define IEC_IDX_MASK_A      8'h05
`define IEC_IDX_MASK_B      8'h06
`define IEC_IDX_MASK_C      8'h07
`define IEC_IDX_EDGE_SEL    8'h11
`define IEC_IDX_CORE        8'h12

`define IEC_RST_MASK        8'h00
`define IEC_RST_EDGE        8'h00
`define IEC_MASK_C_VALID    8'h7F
`define IEC_EDGE_VALID      8'h03
`define IEC_LINE0_BIT       0
`define IEC_LINE1_BIT       1
`define IEC_PEND_A_LINE0    2
`define IEC_PEND_A_LINE1    3
`define IEC_CORE_INHIBIT    0
`define IEC_NSRC            23

`endif

/* File: hdl/iec_pkg.sv */
/*
  types shared by the interrupt enable and edge select block.
  assumes: compiled before any module that names it.
*/
`default_nettype none
package iec_pkg;
  typedef logic [7:0] iec_byte_t;

  typedef struct packed {
    iec_byte_t mask_a;
    iec_byte_t mask_b;
    iec_byte_t mask_c;
    iec_byte_t edge_sel;
    iec_byte_t pend_a;
    iec_byte_t pend_b;
    iec_byte_t pend_c;
    logic      inhibit;
    logic      svc_req;
    logic [4:0] svc_idx;
    logic [31:0] rdata;
  } iec_state_t;

  // one edge detector: last line level, and whether one level has been seen
  typedef struct packed {
    logic line_prev;
    logic primed;
  } iec_edge_state_t;
endpackage
`default_nettype wire

/* File: hdl/iec_edge_detect.sv */
/*
  one external interrupt line: selectable edge detector.
  assumes: line is already synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module iec_edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic line,
  input  wire logic rising_sel,
  output logic      hit
);
  iec_pkg::iec_edge_state_t e_q;
  iec_pkg::iec_edge_state_t e_d;

  // next state: remember this cycle's level, armed after the first sample
  always_comb begin
    e_d           = e_q;
    e_d.line_prev = line;
    e_d.primed    = 1'b1;
  end

  // reset cannot load the live level, so no edge counts until one is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_q.line_prev <= 1'b1;
      e_q.primed    <= 1'b0;
    end else begin
      e_q <= e_d;
    end
  end

  // falling edge when select is 0, rising when 1
  assign hit = e_q.primed & (rising_sel ? (line & ~e_q.line_prev)
                                        : (~line & e_q.line_prev));
endmodule
`default_nettype wire

/* File: tb/iec_top_sva.sv */
/* checker on the iec_top ports: polling, service and register read-back.
   assumes: bound to iec_top; one pclk domain. */
`timescale 1ns/1ps
`default_nettype none
module iec_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        poll,
  input wire logic        service_ack,
  input wire logic        svc_req,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_acc;
  // read access phase, where prdata is valid
  assign rd_acc = psel && penable && !pwrite;
  a_poll_grant: assert property (poll && !service_ack |=> svc_req == $past(irq))
    else $error("grant differs from irq");
  a_grant_cause: assert property ($rose(svc_req) |-> $past(poll))
    else $error("request without poll");
  a_ack_drop: assert property (svc_req && service_ack && !poll |=> !svc_req)
    else $error("request held after ack");
  a_edge_rsvd: assert property (rd_acc && paddr == 32'h44 |-> prdata[31:2] == 30'h0)
    else $error("edge reserved bits set");
  a_grpc_rsvd: assert property (rd_acc && paddr == 32'h1C |-> prdata[31:7] == 25'h0)
    else $error("group c reserved bit set");
  a_hole_err: assert property (psel && penable && paddr == 32'h40 |-> pslverr)
    else $error("unmapped access not refused");
  a_edge_ok: assert property (psel && penable && paddr == 32'h44 |-> pready && !pslverr)
    else $error("edge register refused");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq [*2])
    else $error("irq right after reset");
  c_ack: cover property (svc_req && service_ack);
  c_edge_rd: cover property (rd_acc && paddr == 32'h44);
  c_irq: cover property ($rose(irq));
  c_inhibit_poll: cover property (poll && !irq && !svc_req);
endmodule
`default_nettype wire

/* File: tb/iec_core_model.sv */
/* core model: polls while idle, acknowledges a request SLOW+1 cycles after it rises.
   assumes: svc_req is a registered level from the block. */
`timescale 1ns/1ps
`default_nettype none
module iec_core_model #(
  parameter int SLOW = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic en,
  input  wire logic svc_req,
  output logic      poll,
  output logic      service_ack
);
  logic [3:0] wait_q;
  // no poll while a request is open, so poll never meets an ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll <= 1'b0;
      service_ack <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      poll <= en && !svc_req && !poll && !service_ack;
      service_ack <= svc_req && !service_ack && wait_q == 4'(SLOW);
      wait_q <= (svc_req && !service_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/iec_top_tb_top.sv */
/* self-checking bench for iec_top over apb with a polling core model.
   assumes: lines are synchronous; pending bits clear on a zero write. */
`timescale 1ns/1ps
`default_nettype none
module iec_top_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, en = 0;
  logic l0 = 1, l1 = 1, poll, service_ack, pready, pslverr, svc_req, irq;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [22:0] src_event = 0;
  logic [4:0] svc_idx;
  int n_errors = 0, n_checks = 0;
  always #2.5 pclk = ~pclk;
  iec_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_line_zero(l0), .ext_irq_line_one(l1),
    .src_event(src_event), .poll(poll), .service_ack(service_ack), .svc_req(svc_req),
    .svc_idx(svc_idx), .irq(irq));
  iec_core_model i_core (.pclk(pclk), .presetn(presetn), .en(en), .svc_req(svc_req),
    .poll(poll), .service_ack(service_ack));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one transfer; holds everything until pready is seen high at an edge
  task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [31:0] a, exp, input int err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", exp, q);
    chk("pslverr", 32'(err), {31'h0, e});
  endtask
  task automatic t_regs;
    logic [31:0] ad[4] = '{32'h14, 32'h18, 32'h1C, 32'h44};
    logic [31:0] vm[4] = '{32'hFF, 32'hFF, 32'h7F, 32'h03};
    for (int i = 0; i < 4; i++) begin
      rd(ad[i], 32'h0, 0);
      wr(ad[i], 32'hFFFFFFFF);
      rd(ad[i], vm[i], 0);
      wr(ad[i], 32'h0);
    end
    rd(32'h40, 32'h0, 1);
    rd(32'h45, 32'h0, 1);
    $display("t_regs done");
  endtask
  // every edge setting, each line falling then rising
  task automatic t_edge;
    for (int s = 0; s < 4; s++) begin
      wr(32'h44, 32'(s));
      l0 <= 0;
      l1 <= 0;
      repeat (4) @(posedge pclk);
      rd(32'h08, 32'({~s[1], ~s[0]}) << 2, 0);
      wr(32'h08, 32'h0);
      l0 <= 1;
      l1 <= 1;
      repeat (4) @(posedge pclk);
      rd(32'h08, 32'({s[1], s[0]}) << 2, 0);
      wr(32'h08, 32'h0);
    end
    $display("t_edge done");
  endtask
  task automatic t_pend;
    @(posedge pclk) src_event <= 23'h400001;
    @(posedge pclk) src_event <= 23'h0;
    rd(32'h08, 32'h01, 0);
    rd(32'h10, 32'h40, 0);
    wr(32'h08, 32'hFF);
    rd(32'h08, 32'h01, 0);
    wr(32'h08, 32'h0);
    wr(32'h10, 32'h0);
    rd(32'h08, 32'h0, 0);
    $display("t_pend done");
  endtask
  // grant, service clear, then inhibit holding off two enabled requests
  task automatic t_poll;
    wr(32'h48, 32'h0);
    @(posedge pclk) src_event <= 23'h1;
    @(posedge pclk) src_event <= 23'h0;
    @(negedge pclk) chk("irq", 0, irq);
    wr(32'h14, 32'h1);
    @(negedge pclk) chk("irq", 1, irq);
    @(posedge pclk) en <= 1;
    do @(negedge pclk); while (service_ack !== 1'b1);
    chk("svc_idx", 0, svc_idx);
    repeat (3) @(negedge pclk);
    chk("irq", 0, irq);
    rd(32'h08, 32'h0, 0);
    @(posedge pclk) src_event <= 23'h6;
    @(posedge pclk) src_event <= 23'h0;
    wr(32'h14, 32'h6);
    repeat (4) @(negedge pclk);
    chk("irq", 0, irq);
    chk("svc_req", 0, svc_req);
    wr(32'h48, 32'h0);
    do @(negedge pclk); while (service_ack !== 1'b1);
    chk("svc_idx", 1, svc_idx);
    @(negedge pclk);
    rd(32'h08, 32'h4, 0);
    $display("t_poll done");
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    results;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_edge;
    t_pend;
    t_poll;
    results;
  end
endmodule
bind iec_top iec_top_sva i_sva (
  .pclk        (pclk),
  .presetn     (presetn),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .paddr       (paddr),
  .prdata      (prdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .poll        (poll),
  .service_ack (service_ack),
  .svc_req     (svc_req),
  .irq         (irq)
);
`default_nettype wire
